// ==== ac_link_codec_link_control.sv ====
// Link-side control of the audio codec: straps, resets, power-down, test mode
`timescale 1ns/1ps
`include "ac_link_map.svh"
module ac_link_codec_link_control #(
    parameter bit LATE_REVISION = 1'b0
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        bit_clk_in,
    input  wire logic        crystal_select_strap_in,
    input  wire logic        codec_id_strap_in,
    input  wire logic        sync_in,
    input  wire logic        sdata_out_in,
    input  wire logic [15:0] reg_rd_data_in,
    input  wire logic        reg_rd_valid_in,
    input  wire logic        pcm_valid_in,
    input  wire logic [19:0] pcm_left_in,
    input  wire logic [19:0] pcm_right_in,
    output logic             bit_clk_out,
    output logic             bit_clk_oe_out,
    output logic             sdata_in_out,
    output logic             sdata_in_oe_out,
    output logic             external_amp_powerdown_oe_out,
    output logic             spdif_oe_out,
    output logic             mic_jack_detect_out,
    output logic [1:0]       codec_id_out,
    output ac_link_pkg::clk_src_t clk_src_out,
    output logic             test_mode_out,
    output logic             link_down_out,
    output logic             reg_reset_out,
    output logic             reg_wr_out,
    output logic [6:0]       reg_addr_out,
    output logic [15:0]      reg_wdata_out
);
    // Falling-edge capture of the controller's frame
    logic [7:0]  rx_cnt;
    logic [7:0]  next_rx_cnt;
    logic        sync_q;
    logic [15:0] rx_tag;
    logic [15:0] next_rx_tag;
    logic [19:0] rx_addr;
    logic [19:0] rx_data;
    logic [19:0] next_rx_addr;
    logic [19:0] next_rx_data;
    logic [39:0] cmd_word;
    logic [39:0] next_cmd_word;
    logic        cmd_tgl;
    logic        next_cmd_tgl;
    logic        idle_req;
    logic        next_idle_req;
    always_comb begin
        next_rx_cnt   = (sync_in && !sync_q) ? 8'h01 : rx_cnt + 8'h01;
        next_rx_tag   = rx_tag;
        next_rx_addr  = rx_addr;
        next_rx_data  = rx_data;
        next_cmd_word = cmd_word;
        next_cmd_tgl  = cmd_tgl;
        next_idle_req = (sync_in && !sync_q) ? 1'b0 : idle_req;
        if (sync_in && !sync_q)
            next_rx_tag = {15'h0000, sdata_out_in};
        else if (rx_cnt < `TAG_BITS)
            next_rx_tag = {rx_tag[14:0], sdata_out_in};
        else if (rx_cnt < `TAG_BITS + 8'h14)
            next_rx_addr = {rx_addr[18:0], sdata_out_in};
        else if (rx_cnt < `TAG_BITS + 8'h28)
            next_rx_data = {rx_data[18:0], sdata_out_in};
        // End of slot 2: hand the command across
        if (rx_cnt == `TAG_BITS + 8'h27 && rx_tag[15] && rx_tag[14]) begin
            next_cmd_word = {rx_addr, rx_data[18:0], sdata_out_in};
            next_cmd_tgl  = !cmd_tgl;
            // Power-down write: return data goes quiet from the next rising edge
            if (!rx_addr[19] && rx_addr[18:12] == `REG_PDOWN_INDEX && rx_data[3 + `PDOWN_LINK_BIT])
                next_idle_req = 1'b1;
        end
    end
    always_ff @(negedge bit_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_cnt   <= 8'h00;
            sync_q   <= 1'b0;
            rx_tag   <= 16'h0000;
            rx_addr  <= 20'h00000;
            rx_data  <= 20'h00000;
            cmd_word <= 40'h0000000000;
            cmd_tgl  <= 1'b0;
            idle_req <= 1'b0;
        end else begin
            rx_cnt   <= next_rx_cnt;
            sync_q   <= sync_in;
            rx_tag   <= next_rx_tag;
            rx_addr  <= next_rx_addr;
            rx_data  <= next_rx_data;
            cmd_word <= next_cmd_word;
            cmd_tgl  <= next_cmd_tgl;
            idle_req <= next_idle_req;
        end
    end

    // Incoming bit clock presence, counted in its own domain
    logic [2:0] bclk_cnt;
    logic [2:0] next_bclk_cnt;
    logic       bclk_many;
    logic       next_bclk_many;
    always_comb begin
        next_bclk_cnt  = (bclk_cnt == `CONSUMER_MIN_EDGES) ? bclk_cnt : bclk_cnt + 3'h1;
        next_bclk_many = (bclk_cnt == `CONSUMER_MIN_EDGES);
    end
    always_ff @(posedge bit_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bclk_cnt  <= 3'h0;
            bclk_many <= 1'b0;
        end else begin
            bclk_cnt  <= next_bclk_cnt;
            bclk_many <= next_bclk_many;
        end
    end

    // System-domain view of link and pins
    logic cmd_tgl_s;
    logic sync_s;
    logic sdo_s;
    logic bclk_s;
    logic bmany_s;
    logic xsel_s;
    logic idst_s;
    sync_two_ff u_sync_cmd  (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(cmd_tgl),      .q_out(cmd_tgl_s));
    sync_two_ff u_sync_sync (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(sync_in),      .q_out(sync_s));
    sync_two_ff u_sync_sdo  (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(sdata_out_in), .q_out(sdo_s));
    sync_two_ff u_sync_bclk (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(bit_clk_in),   .q_out(bclk_s));
    sync_two_ff u_sync_many (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(bclk_many),    .q_out(bmany_s));
    sync_two_ff u_sync_xsel (.clk_in(clk_sys_in), .rst_n_in(rst_n_in),
                             .d_in(crystal_select_strap_in), .q_out(xsel_s));
    sync_two_ff u_sync_idst (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .d_in(codec_id_strap_in), .q_out(idst_s));

    // Startup: straps and clock edges are caught in the first cycles after release
    localparam int PDOWN_CNT = (`PDOWN_CYCLES < 1) ? 1 : `PDOWN_CYCLES;
    ac_link_pkg::link_state_t state;
    ac_link_pkg::link_state_t next_state;
    ac_link_pkg::clk_src_t    next_clk_src;
    logic [1:0] next_codec_id;
    logic [2:0] edge_cnt;
    logic [2:0] next_edge_cnt;
    logic       cmd_d;
    logic [3:0] pd_cnt;
    logic [3:0] next_pd_cnt;
    logic       next_bclk_oe;
    logic       next_link_down;
    logic       next_test;
    logic       next_reg_reset;
    logic       next_reg_wr;
    logic [6:0] next_reg_addr;
    logic [15:0] next_reg_wdata;
    logic       cmd_evt;
    assign cmd_evt = cmd_tgl_s ^ cmd_d;
    always_comb begin
        next_state     = state;
        next_clk_src   = clk_src_out;
        next_codec_id  = codec_id_out;
        next_edge_cnt  = edge_cnt;
        next_pd_cnt    = pd_cnt;
        next_bclk_oe   = bit_clk_oe_out;
        next_link_down = link_down_out;
        next_test      = test_mode_out;
        next_reg_reset = 1'b0;
        next_reg_wr    = 1'b0;
        next_reg_addr  = reg_addr_out;
        next_reg_wdata = reg_wdata_out;
        case (state)
            ac_link_pkg::LINK_RESET: begin
                // Decide only once straps and clock presence have crossed their synchronisers
                if (edge_cnt != `STRAP_SETTLE_CYCLES) begin
                    next_edge_cnt = edge_cnt + 3'h1;
                end else begin
                    if (!idst_s && !LATE_REVISION) begin
                        next_codec_id = xsel_s ? `ID_SEC_ONE : `ID_SEC_THREE;
                        next_clk_src  = ac_link_pkg::CLK_LINK_INPUT;
                    end else if (bmany_s) begin
                        next_codec_id = `ID_PRIMARY;
                        next_clk_src  = ac_link_pkg::CLK_LINK_INPUT;
                    end else begin
                        next_codec_id = `ID_PRIMARY;
                        next_clk_src  = xsel_s ? ac_link_pkg::CLK_CRYSTAL_24M : ac_link_pkg::CLK_PLL_14M;
                    end
                    if (sdo_s) begin
                        next_test    = 1'b1;
                        next_bclk_oe = 1'b0;
                        next_state   = ac_link_pkg::LINK_TEST;
                    end else begin
                        next_bclk_oe = !(!idst_s && !LATE_REVISION) && !bmany_s;
                        next_state   = ac_link_pkg::LINK_RUN;
                    end
                end
            end
            ac_link_pkg::LINK_RUN: begin
                if (cmd_evt && !cmd_word[39]) begin
                    next_reg_addr  = cmd_word[38:32];
                    next_reg_wdata = cmd_word[19:4];
                    next_reg_wr    = 1'b1;
                    next_reg_reset = (cmd_word[38:32] == `REG_RESET_INDEX);
                    if (cmd_word[38:32] == `REG_PDOWN_INDEX && cmd_word[4 + `PDOWN_LINK_BIT]) begin
                        // Crossing and decision latency use part of the idle budget
                        next_pd_cnt = 4'(PDOWN_CNT - `PDOWN_LATENCY);
                        next_state  = ac_link_pkg::LINK_DOWN;
                    end
                end
            end
            ac_link_pkg::LINK_DOWN: begin
                if (pd_cnt != 4'h0)
                    next_pd_cnt = pd_cnt - 4'h1;
                else
                    next_link_down = 1'b1;
                if (link_down_out && sync_s && !bclk_s) begin
                    next_link_down = 1'b0;
                    next_state     = ac_link_pkg::LINK_RUN;
                end
            end
            ac_link_pkg::LINK_TEST: next_test = 1'b1;
            default: next_state = ac_link_pkg::LINK_RESET;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state          <= ac_link_pkg::LINK_RESET;
            clk_src_out    <= ac_link_pkg::CLK_CRYSTAL_24M;
            codec_id_out   <= `ID_PRIMARY;
            edge_cnt       <= 3'h0;
            cmd_d          <= 1'b0;
            pd_cnt         <= 4'h0;
            bit_clk_oe_out <= 1'b0;
            link_down_out  <= 1'b0;
            test_mode_out  <= 1'b0;
            reg_reset_out  <= 1'b0;
            reg_wr_out     <= 1'b0;
            reg_addr_out   <= 7'h00;
            reg_wdata_out  <= 16'h0000;
        end else begin
            state          <= next_state;
            clk_src_out    <= next_clk_src;
            codec_id_out   <= next_codec_id;
            edge_cnt       <= next_edge_cnt;
            cmd_d          <= cmd_tgl_s;
            pd_cnt         <= next_pd_cnt;
            bit_clk_oe_out <= next_bclk_oe;
            link_down_out  <= next_link_down;
            test_mode_out  <= next_test;
            reg_reset_out  <= next_reg_reset;
            reg_wr_out     <= next_reg_wr;
            reg_addr_out   <= next_reg_addr;
            reg_wdata_out  <= next_reg_wdata;
        end
    end
    assign mic_jack_detect_out = LATE_REVISION ? idst_s : 1'b0;

    // Bit clock driven out from the system clock when the device is producer
    logic bclk_div;
    logic next_bclk_div;
    always_comb next_bclk_div = !bclk_div;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in)
            bclk_div <= 1'b0;
        else
            bclk_div <= next_bclk_div;
    end
    assign bit_clk_out = bclk_div && !link_down_out;

    // Return frame, launched on rising edge
    logic        rd_l;
    sync_two_ff u_sync_rd (.clk_in(bit_clk_in), .rst_n_in(rst_n_in), .d_in(reg_rd_valid_in), .q_out(rd_l));
    logic [255:0] tx_frame;
    logic [255:0] next_tx_frame;
    logic         next_sdi;
    always_comb begin
        next_tx_frame = {tx_frame[254:0], 1'b0};
        next_sdi      = tx_frame[255];
        if (rx_cnt == `FRAME_BITS) begin
            next_tx_frame = 256'h0;
            next_tx_frame[255]     = 1'b1;
            next_tx_frame[254]     = rd_l;
            next_tx_frame[253]     = rd_l;
            next_tx_frame[252]     = pcm_valid_in;
            next_tx_frame[251]     = pcm_valid_in;
            next_tx_frame[239:220] = {1'b0, cmd_word[38:32], 12'h000};
            next_tx_frame[219:200] = rd_l ? {reg_rd_data_in, 4'h0} : 20'h00000;
            next_tx_frame[199:180] = pcm_valid_in ? pcm_left_in : 20'h00000;
            next_tx_frame[179:160] = pcm_valid_in ? pcm_right_in : 20'h00000;
        end
        if (idle_req)
            next_sdi = 1'b0;
    end
    always_ff @(posedge bit_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_frame     <= 256'h0;
            sdata_in_out <= 1'b0;
        end else begin
            tx_frame     <= next_tx_frame;
            sdata_in_out <= next_sdi;
        end
    end
    assign sdata_in_oe_out = !test_mode_out;
    assign external_amp_powerdown_oe_out     = !test_mode_out;
    assign spdif_oe_out    = !test_mode_out;
endmodule

// ==== ac_link_codec_link_control_assertions.sv ====
// Concurrent checks on the audio link control block ports
`timescale 1ns/1ps
module ac_link_codec_link_control_assertions (
    input wire logic                  clk_sys_in,
    input wire logic                  rst_n_in,
    input wire logic                  bit_clk_out,
    input wire logic                  bit_clk_oe_out,
    input wire logic                  sdata_in_out,
    input wire logic                  sdata_in_oe_out,
    input wire logic                  external_amp_powerdown_oe_out,
    input wire logic                  spdif_oe_out,
    input wire logic [1:0]            codec_id_out,
    input wire ac_link_pkg::clk_src_t clk_src_out,
    input wire logic                  test_mode_out,
    input wire logic                  link_down_out,
    input wire logic                  reg_reset_out,
    input wire logic                  reg_wr_out
);
    logic [3:0] age;
    logic [3:0] next_age;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    always_comb next_age = (age == 4'hF) ? age : age + 4'h1;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) age <= 4'h0;
        else age <= next_age;
    end
    sequence s_quiet;
        !bit_clk_out && !sdata_in_out;
    endsequence
    a_cfg_fixed: assert property ((age >= 4'h8) |-> $stable(codec_id_out) && $stable(clk_src_out))
        else $error("config changed after latch");
    a_test_floats: assert property (test_mode_out |-> !bit_clk_oe_out && !sdata_in_oe_out && !external_amp_powerdown_oe_out && !spdif_oe_out)
        else $error("output driven in test mode");
    a_test_no_cmd: assert property (test_mode_out |-> !reg_wr_out && !reg_reset_out)
        else $error("command taken in test mode");
    a_second_input: assert property ((codec_id_out != 2'h0) |-> clk_src_out == ac_link_pkg::CLK_LINK_INPUT && !bit_clk_oe_out)
        else $error("secondary drives bit clock");
    a_producer_drives: assert property ((age >= 4'h8 && clk_src_out != ac_link_pkg::CLK_LINK_INPUT && !test_mode_out) |-> bit_clk_oe_out)
        else $error("producer not driving bit clock");
    a_down_quiet: assert property ($rose(link_down_out) |-> ##[0:10] s_quiet)
        else $error("link not quiet after power-down");
    a_wr_single: assert property (reg_wr_out |=> !reg_wr_out [*8])
        else $error("write pulse too long or repeated");
    a_reset_single: assert property (reg_reset_out |=> !reg_reset_out)
        else $error("register reset pulse too long");
endmodule
bind ac_link_codec_link_control ac_link_codec_link_control_assertions i_chk (.*);

// ==== ac_link_codec_link_control_test.sv ====
// Self-checking bench for the audio link control block
`timescale 1ns/1ps
`include "ac_link_map.svh"
module ac_link_codec_link_control_test;
    logic        clk_sys_in, rst_n_in, xtl, ids, ate, bck, syn, sdo, bo, boe, sdi, soe, eoe, poe, tm, ld, rr, rw, mj;
    logic [1:0]  cid;
    logic [6:0]  ra;
    logic [15:0] rd;
    logic [31:0] rnd = 32'hC;
    logic [22:0] exp_q[$];
    ac_link_pkg::clk_src_t cs;
    int          fail_count = 0;
    int          n_checks = 0;
    int          resets = 0;
    ac_link_ctrl_model i_ctrl (.ate_in(ate), .bit_clk_out(bck), .sync_out(syn), .sdata_out(sdo));
    ac_link_codec_link_control i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bit_clk_in(boe ? bo : bck),
        .crystal_select_strap_in(xtl), .codec_id_strap_in(ids), .sync_in(syn), .sdata_out_in(sdo),
        .reg_rd_data_in(rnd[15:0]), .reg_rd_valid_in(1'b0), .pcm_valid_in(1'b0), .pcm_left_in(20'h00000),
        .pcm_right_in(20'h00000), .bit_clk_out(bo), .bit_clk_oe_out(boe), .sdata_in_out(sdi),
        .sdata_in_oe_out(soe), .external_amp_powerdown_oe_out(eoe), .spdif_oe_out(poe), .mic_jack_detect_out(mj),
        .codec_id_out(cid), .clk_src_out(cs), .test_mode_out(tm), .link_down_out(ld), .reg_reset_out(rr),
        .reg_wr_out(rw), .reg_addr_out(ra), .reg_wdata_out(rd));
    initial clk_sys_in = 1'b0;
    always #50 clk_sys_in = ~clk_sys_in;
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cold reset with given straps, test request and optional incoming clock
    task automatic cold(input logic x, input logic i, input logic a, input bit c);
        @(negedge clk_sys_in);
        rst_n_in <= 1'b0;
        xtl <= x;
        ids <= i;
        ate <= a;
        if (c) fork i_ctrl.run_clock(40); join_none
        repeat (4) @(negedge clk_sys_in);
        check({rw, tm, ld}, 3'h0);
        rst_n_in <= 1'b1;
        repeat (12) @(negedge clk_sys_in);
        ate <= 1'b0;
    endtask
    task automatic cmd(input logic r, input logic [6:0] a, input logic [15:0] d);
        if (!r && a != `REG_RESET_INDEX) exp_q.push_back({a, d});
        i_ctrl.send_frame(r, a, d);
        repeat (10) @(negedge clk_sys_in);
    endtask
    // Every write pulse, except to the reset register, is matched against the queued expectation
    always @(negedge clk_sys_in) begin
        if (rw === 1'b1 && ra !== `REG_RESET_INDEX) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check({ra, rd}, exp_q.pop_front());
        end
        if (rr === 1'b1) resets++;
    end
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end
    initial begin
        logic [1:0] ie;
        ac_link_pkg::clk_src_t se;
        logic [6:0] a;
        rst_n_in = 1'b0;
        xtl = 1'b1;
        ids = 1'b1;
        ate = 1'b0;
        for (int k = 0; k < 5; k++) begin
            cold(~k[0], ~k[1], 1'b0, k == 4);
            ie = k[1] ? (k[0] ? `ID_SEC_THREE : `ID_SEC_ONE) : `ID_PRIMARY;
            se = (k[1] || k == 4) ? ac_link_pkg::CLK_LINK_INPUT : (k[0] ? ac_link_pkg::CLK_PLL_14M : ac_link_pkg::CLK_CRYSTAL_24M);
            check(cid, ie);
            check(cs, se);
            check(boe, se != ac_link_pkg::CLK_LINK_INPUT);
            check(tm, 1'b0);
            check(mj, 1'b0);
        end
        cold(1'b1, 1'b1, 1'b1, 1'b0);
        check({tm, boe, soe, eoe, poe}, 5'h10);
        cold(1'b1, 1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            rnd = xorshift(rnd);
            a = {rnd[6:1], 1'b0};
            if (a == 7'h00 || a == `REG_PDOWN_INDEX) a = 7'h02;
            cmd(1'b0, a, rnd[31:16]);
        end
        cmd(1'b1, 7'h7F, 16'h0000);
        cmd(1'b0, `REG_RESET_INDEX, rnd[15:0]);
        check(resets, 1);
        // Slot 2 ends 1672 ns into the frame; link must be quiet 1.0 us after that
        fork #2670 check({ld, sdi}, 2'h2); join_none
        cmd(1'b0, `REG_PDOWN_INDEX, 16'h1000);
        check({ld, bo, sdi}, 3'h4);
        i_ctrl.warm_reset();
        repeat (20) @(negedge clk_sys_in);
        check(ld, 1'b0);
        cmd(1'b0, 7'h1E, 16'hA5C3);
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule

// ==== ac_link_ctrl_model.sv ====
// Behavioural AC-link controller that frames commands towards the codec
`timescale 1ns/1ps
module ac_link_ctrl_model (
    input  wire logic ate_in,
    output logic      bit_clk_out,
    output logic      sync_out,
    output logic      sdata_out
);
    logic fbit;
    initial begin
        bit_clk_out = 1'b0;
        sync_out = 1'b0;
        fbit = 1'b0;
    end
    // Data line stays low while reset is held unless test entry is asked for
    assign sdata_out = fbit | ate_in;
    // Free clock across reset release; stands still afterwards
    task automatic run_clock(input int n);
        repeat (n) begin
            #15 bit_clk_out = 1'b1;
            #15 bit_clk_out = 1'b0;
        end
    endtask
    // One frame: sync over the tag, slot data MSB first and justified high
    task automatic send_frame(input logic rw, input logic [6:0] a, input logic [15:0] d);
        logic [255:0] f;
        f = '0;
        f[255:253] = {2'b11, ~rw};
        f[239:220] = {rw, a, 12'h000};
        f[219:204] = d;
        #7;
        for (int i = 255; i >= 0; i--) begin
            bit_clk_out = 1'b1;
            sync_out = (i > 239);
            fbit = f[i];
            #15 bit_clk_out = 1'b0;
            #15;
        end
        sync_out = 1'b0;
        fbit = 1'b0;
    endtask
    task automatic warm_reset();
        sync_out = 1'b1;
        #1200 sync_out = 1'b0;
    endtask
endmodule

// ==== ac_link_map.svh ====
// Constants for the audio link control block
`ifndef AC_LINK_MAP_SVH
`define AC_LINK_MAP_SVH
`define SYS_CLK_HZ          10000000
`define PDOWN_TIME_NS       1000
`define PDOWN_CYCLES        ((`PDOWN_TIME_NS * 10) / 1000)
`define CONSUMER_MIN_EDGES  3'h5
`define STRAP_SETTLE_CYCLES 3'h5
`define PDOWN_LATENCY       5
`define FRAME_BITS          8'hFF
`define TAG_BITS            8'h10
`define SLOT_BITS           5'h14
`define REG_RESET_INDEX     7'h00
`define REG_PDOWN_INDEX     7'h26
`define PDOWN_LINK_BIT      12
`define ID_PRIMARY          2'h0
`define ID_SEC_ONE          2'h1
`define ID_SEC_THREE        2'h3
`endif

// ==== ac_link_pkg.sv ====
// Types for the audio link control block
package ac_link_pkg;
    typedef enum logic [1:0] {
        CLK_CRYSTAL_24M,
        CLK_PLL_14M,
        CLK_LINK_INPUT
    } clk_src_t;
    typedef enum logic [1:0] {
        LINK_RESET,
        LINK_RUN,
        LINK_DOWN,
        LINK_TEST
    } link_state_t;
endpackage

// ==== sync_two_ff.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_two_ff (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic stage1;
    logic next_stage1;
    logic next_q;
    always_comb begin
        next_stage1 = d_in;
        next_q      = stage1;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            q_out  <= next_q;
        end
    end
endmodule
